// *** pkg/lcgs_defines.svh ***
`ifndef LCGS_DEFINES_SVH
`define LCGS_DEFINES_SVH

// ****************************************************************
// register map: six words in an eight-word block per cell, mirror word after
// ****************************************************************
`define LCGS_ADDR_W           12
`define LCGS_CELL_STRIDE      12'h020
`define LCGS_OFS_SRC_SEL1     12'h000
`define LCGS_OFS_SRC_SEL2     12'h004
`define LCGS_OFS_SRC_SEL3     12'h008
`define LCGS_OFS_SRC_SEL4     12'h00c
`define LCGS_OFS_GATE2_SEL    12'h010
`define LCGS_OFS_GATE3_SEL    12'h014
`define LCGS_OFS_MIRROR       12'h080

// ****************************************************************
// field positions inside a gate selector
// ****************************************************************
`define LCGS_IN4_TRUE_BIT     7
`define LCGS_IN4_INV_BIT      6
`define LCGS_IN3_TRUE_BIT     5
`define LCGS_IN3_INV_BIT      4
`define LCGS_IN2_TRUE_BIT     3
`define LCGS_IN2_INV_BIT      2
`define LCGS_IN1_TRUE_BIT     1
`define LCGS_IN1_INV_BIT      0
`define LCGS_SRC_SEL_W        6
`define LCGS_MIRROR_W         4

// ****************************************************************
// reset values
// ****************************************************************
`define LCGS_GATE_SEL_POR     8'h00
`define LCGS_SRC_SEL_POR      6'h00
`define LCGS_MIRROR_RST       4'h0

`endif

// *** pkg/lcgs_pkg.sv ***
`include "lcgs_defines.svh"

package lcgs_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [`LCGS_SRC_SEL_W-1:0] lcgs_src_sel_t;
  typedef logic [7:0]                 lcgs_gate_sel_t;
  typedef logic [`LCGS_MIRROR_W-1:0]  lcgs_mirror_t;

  typedef enum logic [1:0] {
    LCGS_ST_IDLE = 2'b01,
    LCGS_ST_RESP = 2'b10
  } lcgs_apb_st_t;

  typedef enum logic [2:0] {
    LCGS_DEC_NONE   = 3'h0,
    LCGS_DEC_SRC    = 3'h1,
    LCGS_DEC_GATE2  = 3'h2,
    LCGS_DEC_GATE3  = 3'h3,
    LCGS_DEC_MIRROR = 3'h4
  } lcgs_dec_t;

endpackage

// *** design/lcgs_src_mux.sv ***
`timescale 1ns/1ps
`default_nettype none

module lcgs_src_mux
  import lcgs_pkg::*;
#(
  parameter int NUM_SRC = 64
) (
  input  wire logic [NUM_SRC-1:0] sources,
  input  wire lcgs_src_sel_t      sel,
  output logic                    data_out
);

  // a code beyond the source list reads as a constant low
  always_comb begin
    if (int'(sel) < NUM_SRC) begin
      data_out = sources[sel];
    end else begin
      data_out = 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** design/lcgs_gate_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcgs_defines.svh"

module lcgs_gate_sel
  import lcgs_pkg::*;
(
  input  wire logic [3:0]     data_in,
  input  wire lcgs_gate_sel_t enable,
  output logic                gate_out
);

  logic [7:0] terms;

  // true form on the odd bit, inverted form on the even bit of each pair
  always_comb begin
    terms[`LCGS_IN4_TRUE_BIT] = data_in[3];
    terms[`LCGS_IN4_INV_BIT]  = ~data_in[3];
    terms[`LCGS_IN3_TRUE_BIT] = data_in[2];
    terms[`LCGS_IN3_INV_BIT]  = ~data_in[2];
    terms[`LCGS_IN2_TRUE_BIT] = data_in[1];
    terms[`LCGS_IN2_INV_BIT]  = ~data_in[1];
    terms[`LCGS_IN1_TRUE_BIT] = data_in[0];
    terms[`LCGS_IN1_INV_BIT]  = ~data_in[0];
    gate_out = |(terms & enable);
  end

endmodule

`default_nettype wire

// *** design/lcgs_top.sv ***
// Behaviour
// - gate 2 selector bit 7 admits input 4 true, bit 6 its inverse.
// - gate 2 selector bit 5 admits input 3 true, bit 4 its inverse.
// - gate 2 selector bit 3 admits input 2 true, bit 2 its inverse.
// - gate 2 selector bit 1 admits input 1 true, bit 0 its inverse.
// - gate 3 selector bit 7 admits input 4 true, bit 6 its inverse.
// - gate 3 selector bit 5 admits input 3 true, bit 4 its inverse.
// - gate 3 selector bit 3 admits input 2 true, bit 2 its inverse.
// - gate 3 selector bit 1 admits input 1 true, bit 0 its inverse.
// - both selectors fully read/write, set at power-on, kept over other resets.
// - mirror register shows cell outputs 4..1 in bits 3..0, zero after reset.
// - mirror bits 7..4 ignore writes and read zero.
// - each of four data inputs chosen by its own six-bit source field.

`timescale 1ns/1ps
`default_nettype none
`include "lcgs_defines.svh"

module lcgs_top
  import lcgs_pkg::*;
#(
  parameter int NUM_CELLS = 4,
  parameter int NUM_SRC   = 64
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    soft_reset_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`LCGS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [NUM_SRC-1:0]      signal_sources,
  input  wire logic                    cell1_output,
  input  wire logic                    cell2_output,
  input  wire logic                    cell3_output,
  input  wire logic                    cell4_output,
  output logic      [NUM_CELLS-1:0]    gate2_out,
  output logic      [NUM_CELLS-1:0]    gate3_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    lcgs_apb_st_t                           st;
    logic                                   pready;
    logic                                   pslverr;
    logic [31:0]                            prdata;
    lcgs_src_sel_t  [NUM_CELLS-1:0][3:0]    src_sel;
    lcgs_gate_sel_t [NUM_CELLS-1:0]         gate2_sel;
    lcgs_gate_sel_t [NUM_CELLS-1:0]         gate3_sel;
    lcgs_mirror_t                           mirror;
    logic           [NUM_CELLS-1:0]         gate2;
    logic           [NUM_CELLS-1:0]         gate3;
  } lcgs_state_t;

  localparam lcgs_state_t RESET_STATE = '{
    st:        LCGS_ST_IDLE,
    pready:    1'b0,
    pslverr:   1'b0,
    prdata:    32'h0000_0000,
    src_sel:   {(NUM_CELLS*4){`LCGS_SRC_SEL_POR}},
    gate2_sel: {NUM_CELLS{`LCGS_GATE_SEL_POR}},
    gate3_sel: {NUM_CELLS{`LCGS_GATE_SEL_POR}},
    mirror:    `LCGS_MIRROR_RST,
    gate2:     '0,
    gate3:     '0
  };

  lcgs_state_t cur_r;
  lcgs_state_t cur_nxt;

  // ****************************************************************
  // per-cell data input selection and gates
  // ****************************************************************
  logic [NUM_CELLS-1:0][3:0] data_in;
  logic [NUM_CELLS-1:0]      gate2_comb;
  logic [NUM_CELLS-1:0]      gate3_comb;

  genvar gc;
  genvar gi;
  generate
    for (gc = 0; gc < NUM_CELLS; gc++) begin : g_cell
      for (gi = 0; gi < 4; gi++) begin : g_in
        lcgs_src_mux #(
          .NUM_SRC (NUM_SRC)
        ) u_src_mux (
          .sources  (signal_sources),
          .sel      (cur_r.src_sel[gc][gi]),
          .data_out (data_in[gc][gi])
        );
      end

      lcgs_gate_sel u_gate2 (
        .data_in  (data_in[gc]),
        .enable   (cur_r.gate2_sel[gc]),
        .gate_out (gate2_comb[gc])
      );

      lcgs_gate_sel u_gate3 (
        .data_in  (data_in[gc]),
        .enable   (cur_r.gate3_sel[gc]),
        .gate_out (gate3_comb[gc])
      );
    end
  endgenerate

  // ****************************************************************
  // address decode
  // ****************************************************************
  lcgs_dec_t  dec_kind;
  logic [2:0] dec_cell;
  logic [1:0] dec_input;
  logic [2:0] word_idx;

  always_comb begin
    dec_kind  = LCGS_DEC_NONE;
    dec_cell  = paddr[7:5];
    dec_input = paddr[3:2];
    word_idx  = paddr[4:2];
    if (paddr == `LCGS_OFS_MIRROR) begin
      dec_kind = LCGS_DEC_MIRROR;
    end else if (paddr[1:0] == 2'h0 && paddr[11:8] == 4'h0
                 && int'(dec_cell) < NUM_CELLS) begin
      case ({7'h00, word_idx, 2'h0})
        `LCGS_OFS_SRC_SEL1,
        `LCGS_OFS_SRC_SEL2,
        `LCGS_OFS_SRC_SEL3,
        `LCGS_OFS_SRC_SEL4: begin
          dec_kind = LCGS_DEC_SRC;
        end
        `LCGS_OFS_GATE2_SEL: begin
          dec_kind = LCGS_DEC_GATE2;
        end
        `LCGS_OFS_GATE3_SEL: begin
          dec_kind = LCGS_DEC_GATE3;
        end
        default: begin
          dec_kind = LCGS_DEC_NONE;
        end
      endcase
    end
  end

  // ****************************************************************
  // per-cell register select
  // ****************************************************************
  // one select bit per register keeps every array index constant, so a
  // decoded cell number beyond NUM_CELLS can never reach the arrays
  logic [NUM_CELLS-1:0][3:0]  hit_src;
  logic [NUM_CELLS-1:0]       hit_gate2;
  logic [NUM_CELLS-1:0]       hit_gate3;
  logic [NUM_CELLS-1:0][31:0] cell_rd;

  genvar hc;
  genvar hi;
  generate
    for (hc = 0; hc < NUM_CELLS; hc++) begin : g_hit
      logic        cell_match;
      logic [31:0] rd_local;

      assign cell_match    = (int'(dec_cell) == hc);
      assign hit_gate2[hc] = cell_match && (dec_kind == LCGS_DEC_GATE2);
      assign hit_gate3[hc] = cell_match && (dec_kind == LCGS_DEC_GATE3);

      for (hi = 0; hi < 4; hi++) begin : g_src
        assign hit_src[hc][hi] = cell_match && (dec_kind == LCGS_DEC_SRC)
                                 && (int'(dec_input) == hi);
      end

      // upper bits of a source word are not implemented
      always_comb begin
        rd_local = 32'h0000_0000;
        if (hit_gate2[hc]) begin
          rd_local = {24'h00_0000, cur_r.gate2_sel[hc]};
        end else if (hit_gate3[hc]) begin
          rd_local = {24'h00_0000, cur_r.gate3_sel[hc]};
        end else begin
          for (int k = 0; k < 4; k++) begin
            if (hit_src[hc][k]) begin
              rd_local = {26'h000_0000, cur_r.src_sel[hc][k]};
            end
          end
        end
      end

      assign cell_rd[hc] = rd_local;
    end
  endgenerate

  // ****************************************************************
  // read data for the decoded word
  // ****************************************************************
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (dec_kind)
      LCGS_DEC_SRC,
      LCGS_DEC_GATE2,
      LCGS_DEC_GATE3: begin
        // at most one cell word is selected, so an or merges them
        for (int c = 0; c < NUM_CELLS; c++) begin
          rd_word = rd_word | cell_rd[c];
        end
      end
      LCGS_DEC_MIRROR: begin
        rd_word = {28'h000_0000, cur_r.mirror};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  logic wr_take;

  // a write lands only in the access cycle in which pready is high
  assign wr_take = (cur_r.st == LCGS_ST_RESP) && psel && penable
                   && pwrite && pstrb[0];

  always_comb begin
    cur_nxt = cur_r;

    // apb handshake: answer in the first access cycle, no wait states
    case (cur_r.st)
      LCGS_ST_IDLE: begin
        cur_nxt.pready  = 1'b0;
        cur_nxt.pslverr = 1'b0;
        if (psel && !penable) begin
          cur_nxt.st      = LCGS_ST_RESP;
          cur_nxt.pready  = 1'b1;
          cur_nxt.pslverr = (dec_kind == LCGS_DEC_NONE);
          cur_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_word;
        end
      end
      LCGS_ST_RESP: begin
        cur_nxt.st      = LCGS_ST_IDLE;
        cur_nxt.pready  = 1'b0;
        cur_nxt.pslverr = 1'b0;
      end
      default: begin
        cur_nxt.st      = LCGS_ST_IDLE;
        cur_nxt.pready  = 1'b0;
        cur_nxt.pslverr = 1'b0;
      end
    endcase

    // only the low byte lane carries register bits
    // mirror and unmapped words match no select bit and drop the write
    if (wr_take) begin
      for (int c = 0; c < NUM_CELLS; c++) begin
        for (int k = 0; k < 4; k++) begin
          if (hit_src[c][k]) begin
            cur_nxt.src_sel[c][k] = pwdata[`LCGS_SRC_SEL_W-1:0];
          end
        end
        if (hit_gate2[c]) begin
          cur_nxt.gate2_sel[c] = pwdata[7:0];
        end
        if (hit_gate3[c]) begin
          cur_nxt.gate3_sel[c] = pwdata[7:0];
        end
      end
    end

    // mirror follows the cells every cycle; any reset clears it
    if (!soft_reset_n) begin
      cur_nxt.mirror = `LCGS_MIRROR_RST;
    end else begin
      cur_nxt.mirror = {cell4_output, cell3_output,
                        cell2_output, cell1_output};
    end

    cur_nxt.gate2 = gate2_comb;
    cur_nxt.gate3 = gate3_comb;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // presetn stands for power-on and brown-out; the selectors take a
  // defined value there, while soft_reset_n leaves them untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_r <= RESET_STATE;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata    = cur_r.prdata;
  assign pready    = cur_r.pready;
  assign pslverr   = cur_r.pslverr;
  assign gate2_out = cur_r.gate2;
  assign gate3_out = cur_r.gate3;

endmodule

`default_nettype wire

// *** tb/lcgs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcgs_defines.svh"
module lcgs_properties
  import lcgs_pkg::*;
#(
  parameter int NUM_CELLS = 4,
  parameter int NUM_SRC   = 64
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 soft_reset_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [NUM_SRC-1:0]   signal_sources,
  input wire logic                 cell1_output,
  input wire logic                 cell2_output,
  input wire logic                 cell3_output,
  input wire logic                 cell4_output,
  input wire logic [NUM_CELLS-1:0] gate2_out,
  input wire logic [NUM_CELLS-1:0] gate3_out
);
  logic [3:0] cells;
  logic       setup;
  logic       mapped;
  logic       mir_rd;
  logic       wr_done;
  assign cells   = {cell4_output, cell3_output, cell2_output, cell1_output};
  assign setup   = psel && !penable;
  assign mapped  = (paddr == `LCGS_OFS_MIRROR) ||
                   (paddr < `LCGS_OFS_MIRROR && paddr[1:0] == 2'h0 && paddr[4:2] <= 3'h5);
  assign mir_rd  = setup && !pwrite && paddr == `LCGS_OFS_MIRROR;
  assign wr_done = psel && penable && pready && pwrite;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_next: assert property (setup |=> pready) else $error("ready missing");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_decode: assert property (setup |=> pslverr != $past(mapped)) else $error("bad pslverr");
  a_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read data not zero");
  a_sel_upper: assert property (pready && !pwrite && mapped |-> prdata[31:8] == 24'h0)
    else $error("selector upper bits not zero");
  // cells held steady for two clocks, so the one-clock mirror lag cannot matter
  a_mirror_copy: assert property (mir_rd && soft_reset_n && $past(soft_reset_n)
    && $past(presetn) && cells == $past(cells) && cells == $past(cells, 2)
    |=> prdata[3:0] == $past(cells)) else $error("mirror differs from cells");
  a_mirror_soft: assert property (mir_rd && !$past(soft_reset_n) |=> prdata[3:0] == 4'h0)
    else $error("mirror not cleared");
  a_mirror_upper: assert property (pready && !pwrite && paddr == `LCGS_OFS_MIRROR
    |-> prdata[31:4] == 28'h0 && !pslverr) else $error("mirror upper bits set");
  a_gate_idle: assert property ($rose(presetn) |-> (gate2_out == 0 && gate3_out == 0)[*2])
    else $error("gate active after reset");
  a_gate_cause: assert property (!$stable({gate2_out, gate3_out})
    |-> $past(signal_sources) != $past(signal_sources, 2) || $past(wr_done, 2))
    else $error("gate changed without cause");

  c_mirror_read: cover property (mir_rd);
  c_error: cover property (pready && pslverr);
  c_gate_change: cover property (!$stable(gate2_out));
endmodule

bind lcgs_top lcgs_properties #(.NUM_CELLS(NUM_CELLS), .NUM_SRC(NUM_SRC)) i_lcgs_properties (
  .pclk(pclk), .presetn(presetn), .soft_reset_n(soft_reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .signal_sources(signal_sources),
  .cell1_output(cell1_output), .cell2_output(cell2_output), .cell3_output(cell3_output),
  .cell4_output(cell4_output), .gate2_out(gate2_out), .gate3_out(gate3_out)
);
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcgs_defines.svh"
module tb_top
  import lcgs_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        soft_reset_n = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [3:0]  strb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [63:0] srcs = 64'h0;
  logic [3:0]  cells = 4'h0;
  logic [3:0]  g2;
  logic [3:0]  g3;
  logic [31:0] q;
  logic        e;
  int          n_errors = 0;
  int          n_checks = 0;
  lcgs_gate_sel_t s;

  always #10 pclk = ~pclk;

  lcgs_top i_lcgs_top (
    .pclk(pclk), .presetn(presetn), .soft_reset_n(soft_reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .signal_sources(srcs),
    .cell1_output(cells[0]), .cell2_output(cells[1]), .cell3_output(cells[2]),
    .cell4_output(cells[3]), .gate2_out(g2), .gate3_out(g3)
  );

  // ****************************************************************
  // access and checking
  // ****************************************************************
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  // no bound of its own: a missing pready runs into the watchdog, which fails the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask

  function automatic logic [11:0] ad(input int n, input logic [11:0] o);
    return 12'(n) * `LCGS_CELL_STRIDE + o;
  endfunction

  // gate is the OR of admitted terms: odd bits true input, even bits inverted
  function automatic logic eg(input lcgs_gate_sel_t m, input logic [3:0] v);
    logic r;
    r = 1'b0;
    for (int b = 0; b < 8; b++) begin
      if (m[b]) begin
        r = r | (b[0] ? v[b/2] : ~v[b/2]);
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    #400000;
    n_errors++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("gate_out", 32'h0, {24'h0, g3, g2});
    for (int n = 0; n < 4; n++) begin
      rdc("gate2_sel", ad(n, `LCGS_OFS_GATE2_SEL), {24'h0, `LCGS_GATE_SEL_POR});
      wr_sel(n);
    end
    for (int i = 0; i < 10; i++) begin
      s = (i < 8) ? 8'h01 << i : ((i == 8) ? 8'h00 : 8'h82);
      for (int n = 0; n < 4; n++) begin
        apb(1'b1, ad(n, `LCGS_OFS_GATE2_SEL), {24'hffffff, s});
        apb(1'b1, ad(n, `LCGS_OFS_GATE3_SEL), {24'hffffff, ~s});
      end
      for (int v = 0; v < 16; v++) begin
        for (int n = 0; n < 4; n++) srcs[16*n +: 4] <= v[3:0] ^ n[3:0];
        repeat (3) @(posedge pclk);
        for (int n = 0; n < 4; n++) begin
          chk("gate2_out", {31'h0, eg(s, v[3:0] ^ n[3:0])}, {31'h0, g2[n]});
          chk("gate3_out", {31'h0, eg(~s, v[3:0] ^ n[3:0])}, {31'h0, g3[n]});
        end
      end
    end
    for (int p = 0; p < 16; p++) begin
      cells <= p[3:0];
      apb(1'b1, `LCGS_OFS_MIRROR, 32'hffffffff);
      chk("mirror_wr_err", 32'h0, {31'h0, e});
      rdc("mirror", `LCGS_OFS_MIRROR, {28'h0, p[3:0]});
    end
    soft_reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    rdc("mirror_soft", `LCGS_OFS_MIRROR, 32'h0);
    rdc("gate3_kept", ad(3, `LCGS_OFS_GATE3_SEL), 32'h7d);
    soft_reset_n <= 1'b1;
    rdc("gate2_kept", ad(2, `LCGS_OFS_GATE2_SEL), 32'h82);
    strb = 4'he;
    apb(1'b1, ad(0, `LCGS_OFS_GATE2_SEL), 32'h0);
    strb = 4'hf;
    rdc("gate2_strb", ad(0, `LCGS_OFS_GATE2_SEL), 32'h82);
    rdc("unmapped", 12'h018, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    apb(1'b1, 12'h011, 32'hffffffff);
    chk("misaligned_err", 32'h1, {31'h0, e});
    rdc("misaligned_drop", ad(0, `LCGS_OFS_GATE2_SEL), 32'h82);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("gate2_por", ad(1, `LCGS_OFS_GATE2_SEL), {24'h0, `LCGS_GATE_SEL_POR});
    chk("gate_por", 32'h0, {24'h0, g3, g2});
    conclude();
  end

  // source fields take any six-bit code; the 26 upper bits written as ones must read zero
  task automatic wr_sel(input int n);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ad(n, 12'(4*k)), {26'h3ffffff, 6'(16*n + k)});
      rdc("src_sel", ad(n, 12'(4*k)), {26'h0, 6'(16*n + k)});
    end
  endtask
endmodule
`default_nettype wire
